//--- core/fpwm_pin_bits.sv
`default_nettype none
module fpwm_pin_bits
    import fpwm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;
    if (WIDTH < 1) begin : g_width_check
        $error("width too small");
    end
    always_comb begin
        q_next = i_d;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end
    assign o_q = q_reg;
endmodule
`default_nettype wire

//--- core/fpwm_pkg.sv
// Notes on behaviour
// - decode $8000-$BFFF as 16K user window routed to the indexed flash page
// - three index bits pick eight 16K pages: upper two array, low bit half
// - page 6 also fixed at $4000-$7FFF, page 7 also at $C000-$FFFF
// - flash register window $00F4-$00F7 selects array block by index bits 2:1
// - special mode with test select: 32K window $8000-$FFFF, bits 2:1 are A16:A15
// - with emulation enabled, data writes never change pins used for page index emulation; hidden outside single-chip mode when emulation is enabled
// - without emulation pins are general I/O; bit 3 always general I/O
// - peripheral, expanded or special modes with emulation enabled hide data and direction registers
// - chip select low for program window accesses, flash or external
// - chip select during E high, stretched on external access, only when enabled
// - emulation pins show the three page index bits
// - direction bit 0 input, 1 output; resets to zero; hidden outside single-chip mode when emulation is enabled
// - page index holds bits 2:0, reset zero, upper bits read zero
// - far call and return access page index over a dedicated single-wire path
// - input pins selectable as high impedance or pulled up
// - test window select forced to zero in normal modes
// - stretch field adds 0..3 E clocks externally; none in single-chip, peripheral or special
`default_nettype none
package fpwm_pkg;
    localparam logic [7:0] OFS_AUX_DATA = 8'hFC;
    localparam logic [7:0] OFS_AUX_DIR = 8'hFD;
    localparam logic [7:0] OFS_PAGE_INDEX = 8'hFF;
    localparam logic [7:0] OFS_MODE_CTRL = 8'hF0;
    localparam logic [15:0] FREG_LO = 16'h00_F4;
    localparam logic [15:0] FREG_HI = 16'h00_F7;
    localparam logic [1:0] WIN_USER = 2'h2;
    localparam logic [1:0] WIN_FIX6 = 2'h1;
    localparam logic [1:0] WIN_FIX7 = 2'h3;
    localparam logic [2:0] PAGE_FIX6 = 3'h6;
    localparam logic [2:0] PAGE_FIX7 = 3'h7;
    localparam logic [7:0] AUX_IMPL_MASK = 8'h8F;
    localparam logic [7:0] EMUL_MASK = 8'h87;
    localparam int EMUL_CS_BIT = 7;
    localparam logic [7:0] PIDX_MASK = 8'h07;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [2:0] PIDX_RESET = 3'h0;
    localparam int MC_TEST = 0;
    localparam int MC_EMUL = 1;
    localparam int MC_STR_LO = 2;
    localparam int MC_PULLUP = 4;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h1F;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h0C;
    typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPANDED, MODE_PERIPH, MODE_SPECIAL} fpwm_mode_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpwm_reg_req_t;
    typedef struct packed {
        logic valid;
        logic is_flash;
        logic [16:0] addr;
    } fpwm_cpu_req_t;
    typedef struct packed {
        logic hit;
        logic [16:0] flash_addr;
        logic [1:0] freg_array;
        logic freg_hit;
    } fpwm_map_t;
endpackage
`default_nettype wire

//--- core/fpwm_top.sv
`default_nettype none
module fpwm_top
    import fpwm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_mode,
    input wire logic i_eclk_high,
    input wire logic i_ext_access,
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_valid,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic i_far_wr,
    input wire logic i_far_bit,
    input wire logic [7:0] i_aux_pin,
    output logic [7:0] o_reg_rdata,
    output logic o_far_bit,
    output logic o_flash_hit,
    output logic [16:0] o_flash_addr,
    output logic o_freg_hit,
    output logic [1:0] o_freg_array,
    output logic [7:0] o_aux_out,
    output logic [7:0] o_aux_oe,
    output logic [7:0] o_aux_pullup,
    output logic [1:0] o_stretch_eclks
);
    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    fpwm_mode_t mode;
    assign mode = fpwm_mode_t'(i_mode);

    logic [2:0] pidx_reg, pidx_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] dir_reg, dir_next;
    logic [7:0] mctl_reg, mctl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic far_bit_reg, far_bit_next;
    logic [1:0] far_cnt_reg, far_cnt_next;

    logic emul_en, test_sel, aux_mapped;
    assign emul_en = mctl_reg[MC_EMUL];
    assign test_sel = mctl_reg[MC_TEST] && (mode == MODE_SPECIAL);
    assign aux_mapped = !((mode != MODE_SINGLE) && emul_en);

    function automatic logic is_wr(input logic [7:0] a);
        return i_reg_wr && (i_reg_addr == a);
    endfunction

    always_comb begin
        pidx_next = pidx_reg;
        data_next = data_reg;
        dir_next = dir_reg;
        mctl_next = mctl_reg;
        far_cnt_next = far_cnt_reg;
        far_bit_next = pidx_reg[far_cnt_reg];
        if (is_wr(OFS_PAGE_INDEX)) begin
            pidx_next = i_reg_wdata[2:0];
        end
        if (i_far_wr) begin
            pidx_next[far_cnt_reg] = i_far_bit;
            far_cnt_next = (far_cnt_reg == 2'd2) ? 2'd0 : far_cnt_reg + 2'd1;
        end
        if (is_wr(OFS_AUX_DATA) && aux_mapped) begin
            data_next = (i_reg_wdata & AUX_IMPL_MASK & ~(emul_en ? EMUL_MASK : 8'h00))
                | (data_reg & (emul_en ? EMUL_MASK : 8'h00));
        end
        if (is_wr(OFS_AUX_DIR) && aux_mapped) begin
            dir_next = i_reg_wdata & AUX_IMPL_MASK;
        end
        if (is_wr(OFS_MODE_CTRL)) begin
            mctl_next = i_reg_wdata & MODE_CTRL_MASK;
        end
        rdata_next = 8'h00;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                OFS_PAGE_INDEX: rdata_next = {5'h00, pidx_reg};
                OFS_AUX_DATA: rdata_next = aux_mapped ?
                    (((dir_reg & data_reg) | (~dir_reg & i_aux_pin)) & AUX_IMPL_MASK) : 8'h00;
                OFS_AUX_DIR: rdata_next = aux_mapped ? dir_reg : 8'h00;
                OFS_MODE_CTRL: rdata_next = mctl_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pidx_reg <= PIDX_RESET;
            data_reg <= 8'h00;
            dir_reg <= DIR_RESET;
            mctl_reg <= MODE_CTRL_RESET;
            rdata_reg <= 8'h00;
            far_bit_reg <= 1'b0;
            far_cnt_reg <= 2'd0;
        end else begin
            pidx_reg <= pidx_next;
            data_reg <= data_next;
            dir_reg <= dir_next;
            mctl_reg <= mctl_next;
            rdata_reg <= rdata_next;
            far_bit_reg <= far_bit_next;
            far_cnt_reg <= far_cnt_next;
        end
    end

    fpwm_map_t map;
    logic in_prog;
    always_comb begin
        map = '0;
        in_prog = 1'b0;
        if (i_cpu_valid) begin
            if (test_sel && i_cpu_addr[15]) begin
                map.hit = 1'b1;
                map.flash_addr = {pidx_reg[2:1], i_cpu_addr[14:0]};
                in_prog = 1'b1;
            end else if (i_cpu_addr[15:14] == WIN_USER) begin
                map.hit = 1'b1;
                map.flash_addr = {pidx_reg, i_cpu_addr[13:0]};
                in_prog = 1'b1;
            end else if (i_cpu_addr[15:14] == WIN_FIX6) begin
                map.hit = 1'b1;
                map.flash_addr = {PAGE_FIX6, i_cpu_addr[13:0]};
            end else if (i_cpu_addr[15:14] == WIN_FIX7) begin
                map.hit = 1'b1;
                map.flash_addr = {PAGE_FIX7, i_cpu_addr[13:0]};
            end
            if (i_cpu_addr >= FREG_LO && i_cpu_addr <= FREG_HI) begin
                map.freg_hit = 1'b1;
                map.freg_array = pidx_reg[2:1];
            end
        end
    end

    logic [1:0] str_cnt_reg, str_cnt_next;
    logic cs_reg, cs_next;
    logic [1:0] stretch_reg, stretch_next;
    always_comb begin
        stretch_next = (mode == MODE_EXPANDED) ? mctl_reg[MC_STR_LO +: 2] : 2'd0;
        str_cnt_next = str_cnt_reg;
        cs_next = 1'b0;
        if (emul_en && in_prog && i_eclk_high) begin
            cs_next = 1'b1;
            str_cnt_next = i_ext_access ? stretch_next : 2'd0;
        end else if (emul_en && cs_reg && str_cnt_reg != 2'd0) begin
            cs_next = 1'b1;
            str_cnt_next = str_cnt_reg - 2'd1;
        end
    end

    logic [7:0] pin_out_next, pin_oe_next, pin_out_q, pin_oe_q;
    always_comb begin
        pin_out_next = data_reg & AUX_IMPL_MASK;
        pin_oe_next = dir_reg & AUX_IMPL_MASK;
        if (emul_en) begin
            pin_out_next[2:0] = pidx_reg;
            pin_out_next[EMUL_CS_BIT] = !cs_next;
            pin_oe_next = pin_oe_next | EMUL_MASK;
        end
    end

    fpwm_pin_bits #(.WIDTH(16)) u_pins (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d({pin_out_next, pin_oe_next}),
        .o_q({pin_out_q, pin_oe_q})
    );

    logic [7:0] pull_reg;
    logic hit_reg, fhit_reg;
    logic [16:0] faddr_reg;
    logic [1:0] farr_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            str_cnt_reg <= 2'd0;
            cs_reg <= 1'b0;
            stretch_reg <= 2'd0;
            pull_reg <= 8'h00;
            hit_reg <= 1'b0;
            fhit_reg <= 1'b0;
            faddr_reg <= '0;
            farr_reg <= 2'd0;
        end else begin
            str_cnt_reg <= str_cnt_next;
            cs_reg <= cs_next;
            stretch_reg <= stretch_next;
            pull_reg <= mctl_reg[MC_PULLUP] ? (~pin_oe_next & AUX_IMPL_MASK) : 8'h00;
            hit_reg <= map.hit;
            fhit_reg <= map.freg_hit;
            faddr_reg <= map.flash_addr;
            farr_reg <= map.freg_array;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_far_bit = far_bit_reg;
    assign o_flash_hit = hit_reg;
    assign o_flash_addr = faddr_reg;
    assign o_freg_hit = fhit_reg;
    assign o_freg_array = farr_reg;
    assign o_aux_out = pin_out_q;
    assign o_aux_oe = pin_oe_q;
    assign o_aux_pullup = pull_reg;
    assign o_stretch_eclks = stretch_reg;

    property p_user_addr;
        @(posedge i_clk) disable iff (!rst_n)
        (i_cpu_valid && !test_sel && i_cpu_addr[15:14] == 2'b10)
            |=> (o_flash_hit && o_flash_addr == {$past(pidx_reg), $past(i_cpu_addr[13:0])});
    endproperty
    a_user_addr: assert property (p_user_addr) else $error("user window address wrong");
    property p_fix7;
        @(posedge i_clk) disable iff (!rst_n)
        (i_cpu_valid && !test_sel && i_cpu_addr[15:14] == 2'b11) |=> o_flash_addr[16:14] == 3'h7;
    endproperty
    a_fix7: assert property (p_fix7) else $error("fixed page 7 wrong");
    property p_freg;
        @(posedge i_clk) disable iff (!rst_n)
        (i_cpu_valid && i_cpu_addr == 16'h00_F6) |=> (o_freg_hit && o_freg_array == $past(pidx_reg[2:1]));
    endproperty
    a_freg: assert property (p_freg) else $error("register window wrong");
    property p_test;
        @(posedge i_clk) disable iff (!rst_n)
        (i_cpu_valid && test_sel && i_cpu_addr[15]) |=> o_flash_addr[16:15] == $past(pidx_reg[2:1]);
    endproperty
    a_test: assert property (p_test) else $error("test window wrong");
    property p_pidx_rd;
        @(posedge i_clk) disable iff (!rst_n)
        (i_reg_rd && i_reg_addr == OFS_PAGE_INDEX) |=> o_reg_rdata == {5'h00, $past(pidx_reg)};
    endproperty
    a_pidx_rd: assert property (p_pidx_rd) else $error("page index readback wrong");
    property p_emul_pins;
        @(posedge i_clk) disable iff (!rst_n)
        emul_en |=> o_aux_out[2:0] == $past(pidx_reg) && o_aux_oe[2:0] == 3'h7;
    endproperty
    a_emul_pins: assert property (p_emul_pins) else $error("emulation pins wrong");
    property p_cs_off;
        @(posedge i_clk) disable iff (!rst_n)
        !emul_en |=> !cs_reg;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("chip select without enable");
    property p_hidden;
        @(posedge i_clk) disable iff (!rst_n)
        (i_reg_wr && i_reg_addr == OFS_AUX_DIR && !aux_mapped) |=> $stable(dir_reg);
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden register written");
    property p_nostr;
        @(posedge i_clk) disable iff (!rst_n)
        (mode != MODE_EXPANDED) |=> o_stretch_eclks == 2'd0;
    endproperty
    a_nostr: assert property (p_nostr) else $error("stretch outside expanded");
    property p_data_keep;
        @(posedge i_clk) disable iff (!rst_n)
        (i_reg_wr && i_reg_addr == OFS_AUX_DATA && emul_en)
            |=> (data_reg & EMUL_MASK) == $past(data_reg & EMUL_MASK);
    endproperty
    a_data_keep: assert property (p_data_keep) else $error("emulated data bits changed");
    property p_test_off;
        @(posedge i_clk) disable iff (!rst_n)
        (i_cpu_valid && mode != MODE_SPECIAL && i_cpu_addr[15:14] == 2'b11)
            |=> o_flash_addr[16:14] == 3'h7;
    endproperty
    a_test_off: assert property (p_test_off) else $error("test window outside special");
    property p_cs_on;
        @(posedge i_clk) disable iff (!rst_n)
        (emul_en && i_cpu_valid && i_eclk_high && i_cpu_addr[15:14] == 2'b10)
            |=> !o_aux_out[EMUL_CS_BIT];
    endproperty
    a_cs_on: assert property (p_cs_on) else $error("chip select missing");
    property p_pull;
        @(posedge i_clk) disable iff (!rst_n)
        (mctl_reg[MC_PULLUP] && !emul_en && dir_reg == 8'h00)
            |=> o_aux_pullup == AUX_IMPL_MASK;
    endproperty
    a_pull: assert property (p_pull) else $error("input pull-up missing");
endmodule
`default_nettype wire

//--- test/flash_page_window_mapper_tb_top.sv
`default_nettype none
module flash_page_window_mapper_tb_top;
    import fpwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = 2'h0;
    logic eclk_high = 1'b0;
    logic ext_access = 1'b0;
    logic far_rd;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic far_wr = 1'b0;
    logic far_bit = 1'b0;
    logic [7:0] aux_pin;
    logic [7:0] rdata;
    logic hit;
    logic [16:0] faddr;
    logic freg_hit;
    logic [1:0] freg_array;
    logic [7:0] aux_out;
    logic [7:0] aux_oe;
    logic [7:0] aux_pullup;
    logic [1:0] stretch;
    int n_errors = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    fpwm_top u_dut (.i_clk(clk), .i_nrst(nrst), .i_mode(mode), .i_eclk_high(eclk_high),
        .i_ext_access(ext_access), .i_cpu_addr(cpu_addr), .i_cpu_valid(cpu_valid),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .i_far_wr(far_wr), .i_far_bit(far_bit), .i_aux_pin(aux_pin),
        .o_reg_rdata(rdata), .o_far_bit(far_rd), .o_flash_hit(hit), .o_flash_addr(faddr),
        .o_freg_hit(freg_hit), .o_freg_array(freg_array), .o_aux_out(aux_out),
        .o_aux_oe(aux_oe), .o_aux_pullup(aux_pullup), .o_stretch_eclks(stretch));
    fpwm_pin_partner u_pins (.i_clk(clk), .i_out(aux_out), .i_oe(aux_oe),
        .i_pullup(aux_pullup), .o_pin(aux_pin));
    task automatic cmp(input string n, input logic [16:0] e, input logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e,
        input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp(n, {9'h0, e}, {9'h0, rdata & m});
    endtask
    task automatic map(input logic [15:0] a);
        @(posedge clk);
        cpu_addr <= a;
        cpu_valid <= 1'b1;
        @(posedge clk);
        cpu_valid <= 1'b0;
        #1;
    endtask
    task automatic settle();
        @(posedge clk);
        @(posedge clk);
        #1;
    endtask
    task automatic t_far();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            far_wr <= 1'b1;
            far_bit <= (i != 1);
        end
        @(posedge clk);
        far_wr <= 1'b0;
        rd("page_far", OFS_PAGE_INDEX, 8'h05, 8'hFF);
        cmp("far_read", 17'h0_0001, {16'h0, far_rd});
    endtask
    task automatic t_reset_vals();
        wr(OFS_PAGE_INDEX, 8'h00);
        rd("dir_reset", OFS_AUX_DIR, 8'h00, 8'hFF);
        wr(OFS_PAGE_INDEX, 8'hFF);
        rd("page_upper", OFS_PAGE_INDEX, 8'h07, 8'hFF);
        cmp("stretch_single", 17'h0_0000, {15'h0, stretch});
    endtask
    task automatic t_pages();
        logic [15:0] a;
        for (int p = 0; p < 8; p++) begin
            a = 16'h8000 + 16'(p) * 16'h0523;
            wr(OFS_PAGE_INDEX, 8'(p));
            map(a);
            cmp("user_hit", 17'h0_0001, {16'h0, hit});
            cmp("user_addr", {3'(p), a[13:0]}, faddr);
            map(16'h00F4 + 16'(p % 4));
            cmp("freg_hit", 17'h0_0001, {16'h0, freg_hit});
            cmp("freg_array", {15'h0, 2'(p >> 1)}, {15'h0, freg_array});
        end
        map(16'h4ABC);
        cmp("fix6_addr", {3'h6, 14'h0ABC}, faddr);
        map(16'hFFFE);
        cmp("fix7_addr", {3'h7, 14'h3FFE}, faddr);
        map(16'h00F8);
        cmp("freg_miss", 17'h0_0000, {16'h0, freg_hit});
    endtask
    task automatic t_test_win();
        wr(OFS_PAGE_INDEX, 8'h03);
        wr(OFS_MODE_CTRL, 8'h0D);
        map(16'h9234);
        cmp("test_normal", {3'h3, 14'h1234}, faddr);
        @(posedge clk);
        mode <= 2'h3;
        wr(OFS_MODE_CTRL, 8'h0D);
        map(16'hF234);
        cmp("test_win", {2'h1, 15'h7234}, faddr);
        @(posedge clk);
        mode <= 2'h2;
        map(16'hF234);
        cmp("test_periph", {3'h7, 14'h3234}, faddr);
        wr(OFS_MODE_CTRL, 8'h0C);
        @(posedge clk);
        mode <= 2'h0;
    endtask
    task automatic t_aux();
        wr(OFS_AUX_DIR, 8'h8F);
        wr(OFS_AUX_DATA, 8'h8D);
        settle();
        cmp("aux_oe", 17'h0_008F, {9'h0, aux_oe & 8'h8F});
        cmp("aux_out", 17'h0_008D, {9'h0, aux_out & 8'h8F});
        rd("aux_data", OFS_AUX_DATA, 8'h8D, 8'h8F);
        wr(OFS_AUX_DIR, 8'h00);
        wr(OFS_MODE_CTRL, 8'h1C);
        settle();
        cmp("pullup", 17'h0_008F, {9'h0, aux_pullup & 8'h8F});
        cmp("pin_pulled", 17'h0_008F, {9'h0, aux_pin & 8'h8F});
        rd("aux_in", OFS_AUX_DATA, 8'h8F, 8'h8F);
        wr(OFS_MODE_CTRL, 8'h0C);
    endtask
    task automatic t_emul();
        wr(OFS_AUX_DIR, 8'h8F);
        wr(OFS_AUX_DATA, 8'h00);
        wr(OFS_PAGE_INDEX, 8'h05);
        wr(OFS_MODE_CTRL, 8'h0E);
        wr(OFS_AUX_DATA, 8'h0A);
        settle();
        cmp("emul_bits", 17'h0_000D, {13'h0, aux_out[3:0]});
        cmp("cs_idle", 17'h0_0001, {16'h0, aux_out[7]});
        @(posedge clk);
        eclk_high <= 1'b1;
        map(16'h8123);
        cmp("cs_active", 17'h0_0000, {16'h0, aux_out[7]});
        @(posedge clk);
        eclk_high <= 1'b0;
        mode <= 2'h1;
        wr(OFS_AUX_DIR, 8'h00);
        rd("dir_hidden", OFS_AUX_DIR, 8'h00, 8'hFF);
        cmp("stretch_exp", 17'h0_0003, {15'h0, stretch});
        @(posedge clk);
        eclk_high <= 1'b1;
        ext_access <= 1'b1;
        map(16'h8123);
        for (int i = 0; i < 4; i++) begin
            cmp("cs_stretch", 17'h0_0000, {16'h0, aux_out[7]});
            @(posedge clk);
            eclk_high <= 1'b0;
            ext_access <= 1'b0;
            #1;
        end
        cmp("cs_end", 17'h0_0001, {16'h0, aux_out[7]});
        @(posedge clk);
        mode <= 2'h0;
        rd("dir_kept", OFS_AUX_DIR, 8'h8F, 8'hFF);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_far();
        t_reset_vals();
        t_pages();
        t_test_win();
        t_aux();
        t_emul();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire

//--- test/fpwm_pin_partner.sv
`default_nettype none
module fpwm_pin_partner
    import fpwm_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pullup,
    output logic [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_reg = 8'h55;
    // a floating pin must not look stable
    always @(posedge i_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_pin[i] = i_oe[i] ? i_out[i] : (i_pullup[i] ? 1'b1 : float_reg[i]);
        end
    end
endmodule
`default_nettype wire
